// ---- rtl/mixer_gain_gating_command_decoder.sv ----
// Gain and gating command decoder with an AXI4-Lite register port.
// Assumes a serial front end that parses frames into header and argument
// words and that formats the reply word back into binary or text.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`include "mixer_gate_defines.svh"

module mixer_gain_gating_command_decoder
  import mixer_gate_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  gate_on_i,
  input  wire logic [3:0]  line_present_i,
  output logic             report_en_o,
  output logic [15:0]      gain_o [CHANNELS],
  output logic [CHANNELS-1:0] mute_o
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic        aw_held_reg, aw_held_next;
  logic        w_held_reg, w_held_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic        bvalid_next, rvalid_next;
  logic [31:0] rdata_next;
  logic [1:0]  bresp_next, rresp_next;
  logic        do_write;
  logic        do_read;
  logic [31:0] arg_reg, arg_next;
  cmd_word_s   cmd_reg, cmd_next;
  logic        exec_reg, exec_next;
  logic [31:0] reply_reg, reply_next;
  logic        report_next;
  logic [23:0] pass_reg, pass_next;
  arg_word_s   arg;

  assign arg           = arg_word_s'(arg_reg);
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
    end
    do_write    = aw_held_next && w_held_next && !s_axi_bvalid;
    bvalid_next = s_axi_bvalid && !s_axi_bready;
    bresp_next  = s_axi_bresp;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      case (awaddr_next)
        `CMD_ADDR, `ARG_ADDR, `PASS_ADDR: bresp_next = 2'b00;
        default:                          bresp_next = 2'b10;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  // A write to the command register launches one command; its reply is
  // ready in the reply register two cycles after the write response.
  logic [15:0] gain_sel;
  logic [17:0] gain_sum;
  logic [17:0] gain_tgt;
  logic [15:0] hold_q [CHANNELS];
  logic [15:0] ratio_q [CHANNELS];
  gate_mode_e  mode_q [CHANNELS];
  logic [3:0]  group_q [CHANNELS];
  logic [CHANNELS-1:0] over_q;
  logic [15:0] gain_next [CHANNELS];
  logic [CHANNELS-1:0] mute_next;
  logic [2:0]  ch;
  logic        ch_ok;

  assign ch    = 3'(arg.channel - 8'h01);
  assign ch_ok = arg.channel >= 8'h01 && arg.channel <= 8'(CHANNELS);

  always_comb begin
    arg_next    = arg_reg;
    cmd_next    = cmd_reg;
    pass_next   = pass_reg;
    exec_next   = 1'b0;
    report_next = report_en_o;
    reply_next  = reply_reg;
    gain_next   = gain_o;
    mute_next   = mute_o;
    gain_sel    = gain_o[ch];
    gain_sum    = 18'($signed(gain_sel)) + 18'($signed(arg.value));
    gain_tgt    = cmd_reg.absolute ? 18'($signed(arg.value)) : gain_sum;
    if (do_write && awaddr_next == `ARG_ADDR) begin
      arg_next = wdata_next;
    end
    if (do_write && awaddr_next == `PASS_ADDR) begin
      pass_next = wdata_next[23:0];
    end
    if (do_write && awaddr_next == `CMD_ADDR) begin
      cmd_next  = cmd_word_s'(wdata_next[10:0]);
      exec_next = 1'b1;
    end
    if (exec_reg) begin
      reply_next = arg_reg;
      case (cmd_reg.id)
        `ID_GAIN: begin
          if (ch_ok && !cmd_reg.no_value) begin
            if ($signed(gain_tgt) < $signed(18'(`GAIN_MIN))) begin
              mute_next[ch] = 1'b1;
              gain_next[ch] = `GAIN_MIN;
            end else if ($signed(gain_tgt) > $signed(18'(`GAIN_MAX))) begin
              mute_next[ch] = 1'b0;
              gain_next[ch] = `GAIN_MAX;
            end else begin
              mute_next[ch] = 1'b0;
              gain_next[ch] = gain_tgt[15:0];
            end
          end
        end
        `ID_GATE_STAT: begin
          reply_next = {24'h000000, gate_on_i};
          if (cmd_reg.text_form) begin
            reply_next[11:8] = line_present_i;
          end
        end
        `ID_REPORT: begin
          if (!cmd_reg.no_value) begin
            case (arg_reg)
              32'h00000000: report_next = 1'b0;
              32'h00000001: report_next = 1'b1;
              32'h00000002: report_next = !report_en_o;
              default:      report_next = report_en_o;
            endcase
          end
        end
        `ID_PASSCODE: reply_next = {pass_reg, 8'h00};
        default: begin
        end
      endcase
    end
  end

  // Reply stage: built one cycle after execution so it shows stored values.
  logic        reply_stage_reg;
  logic [31:0] reply_fix;
  always_comb begin
    reply_fix = reply_reg;
    if (reply_stage_reg && ch_ok) begin
      case (cmd_reg.id)
        `ID_GAIN:     reply_fix[15:0] = gain_o[ch];
        `ID_HOLD:     reply_fix[15:0] = hold_q[ch];
        `ID_RATIO:    reply_fix[15:0] = ratio_q[ch];
        `ID_MODE:     reply_fix[15:0] = {14'h0000, mode_q[ch]};
        `ID_ASSIGN:   reply_fix[15:0] = {12'h000, group_q[ch]};
        `ID_OVERRIDE: reply_fix[15:0] = {15'h0000, over_q[ch]};
        default: begin
        end
      endcase
    end
    if (reply_stage_reg && cmd_reg.id == `ID_REPORT) begin
      reply_fix = {31'h00000000, report_en_o};
    end
    rvalid_next = s_axi_rvalid && !s_axi_rready;
    rdata_next  = s_axi_rdata;
    rresp_next  = s_axi_rresp;
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = 2'b00;
      case (s_axi_araddr)
        `CMD_ADDR:   rdata_next = {21'h000000, cmd_reg};
        `ARG_ADDR:   rdata_next = arg_reg;
        `REPLY_ADDR: rdata_next = reply_reg;
        `STAT_ADDR:  rdata_next = {29'h00000000, cmd_reg.text_form,
                                   report_en_o, exec_reg | reply_stage_reg};
        `GATE_ADDR:  rdata_next = {20'h00000, line_present_i, gate_on_i};
        `PASS_ADDR:  rdata_next = {8'h00, pass_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = 2'b10;
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      mic_gate_channel u_chan (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .sel_i      (ch_ok && ch == 3'(gi) && arg.group == `GRP_MIC),
        .exec_i     (exec_reg),
        .id_i       (cmd_reg.id),
        .no_value_i (cmd_reg.no_value),
        .value_i    (arg.value),
        .hold_o     (hold_q[gi]),
        .ratio_o    (ratio_q[gi]),
        .mode_o     (mode_q[gi]),
        .group_o    (group_q[gi]),
        .override_o (over_q[gi])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h00000000;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= 2'b00;
      s_axi_rvalid    <= 1'b0;
      s_axi_rdata     <= 32'h00000000;
      s_axi_rresp     <= 2'b00;
      arg_reg         <= 32'h00000000;
      cmd_reg         <= '0;
      exec_reg        <= 1'b0;
      reply_stage_reg <= 1'b0;
      reply_reg       <= 32'h00000000;
      report_en_o     <= 1'b0;
      pass_reg        <= `PASS_RESET;
      mute_o          <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        gain_o[i] <= 16'h0000;
      end
    end else begin
      aw_held_reg     <= aw_held_next;
      w_held_reg      <= w_held_next;
      awaddr_reg      <= awaddr_next;
      wdata_reg       <= wdata_next;
      s_axi_bvalid    <= bvalid_next;
      s_axi_bresp     <= bresp_next;
      s_axi_rvalid    <= rvalid_next;
      s_axi_rdata     <= rdata_next;
      s_axi_rresp     <= rresp_next;
      arg_reg         <= arg_next;
      cmd_reg         <= cmd_next;
      exec_reg        <= exec_next;
      reply_stage_reg <= exec_reg;
      reply_reg       <= reply_stage_reg ? reply_fix : reply_next;
      report_en_o     <= report_next;
      pass_reg        <= pass_next;
      mute_o          <= mute_next;
      gain_o          <= gain_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_gate_status;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_reg && cmd_reg.id == `ID_GATE_STAT
      |=> reply_reg[7:0] == $past(gate_on_i);
  endproperty
  a_gate_status: assert property (p_gate_status)
    else $error("gate status reply wrong");
  sequence s_cmd_write;
    do_write && awaddr_next == `CMD_ADDR;
  endsequence
  sequence s_exec_reply;
    exec_reg ##1 reply_stage_reg && !exec_reg;
  endsequence
  property p_cmd_pipeline;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_cmd_write |=> s_exec_reply;
  endproperty
  a_cmd_pipeline: assert property (p_cmd_pipeline)
    else $error("command pipeline step missing");
  property p_gain_range;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_reg && cmd_reg.id == `ID_GAIN && ch_ok && !cmd_reg.no_value
      |=> $signed(gain_o[$past(ch)]) <= $signed(`GAIN_MAX)
       && $signed(gain_o[$past(ch)]) >= $signed(`GAIN_MIN);
  endproperty
  a_gain_range: assert property (p_gain_range)
    else $error("gain out of range");
  property p_report_toggle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_reg && cmd_reg.id == `ID_REPORT && !cmd_reg.no_value
      && arg_reg == 32'h00000002 |=> report_en_o != $past(report_en_o);
  endproperty
  a_report_toggle: assert property (p_report_toggle)
    else $error("no toggle");
  property p_noval_keeps;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      exec_reg && cmd_reg.no_value |=> $stable(report_en_o) && $stable(mute_o);
  endproperty
  a_noval_keeps: assert property (p_noval_keeps)
    else $error("changed");
endmodule

// ---- rtl/mixer_gate_defines.svh ----
// Offsets, field positions, limits and codes of the gain and gating decoder.
// Assumes it is included by bare name from the design files and the testbench.
`ifndef MIXER_GATE_DEFINES_SVH
`define MIXER_GATE_DEFINES_SVH
`define ID_GAIN        8'h12
`define ID_GATE_STAT   8'h13
`define ID_HOLD        8'h14
`define ID_MODE        8'h15
`define ID_REPORT      8'h19
`define ID_ASSIGN      8'h23
`define ID_RATIO       8'h16
`define ID_OVERRIDE    8'h17
`define ID_PASSCODE    8'h11
`define GRP_IN         8'h01
`define GRP_OUT        8'h02
`define GRP_MIC        8'h03
`define GRP_PROC       8'h05
`define GRP_LINE       8'h07
`define GAIN_MIN       16'shffbf
`define GAIN_MAX       16'sh0014
`define HOLD_MIN       16'h000a
`define HOLD_MAX       16'h0320
`define RATIO_MAX      16'h0032
`define CMD_ADDR       8'h00
`define ARG_ADDR       8'h04
`define REPLY_ADDR     8'h08
`define STAT_ADDR      8'h0c
`define GATE_ADDR      8'h10
`define PASS_ADDR      8'h14
`define STAT_BUSY      0
`define STAT_REPORT    1
`define STAT_TEXT      2
`define FLAG_NOVAL     8
`define FLAG_ABS       9
`define FLAG_TEXT      10
`define PASS_RESET     24'h000000
`define HOLD_RESET     16'h0064
`endif

// ---- rtl/mixer_gate_pkg.sv ----
// Types shared by the gain and gating decoder files.
// Assumes mixer_gate_defines.svh is compiled with it.
package mixer_gate_pkg;
  typedef struct packed {
    logic [7:0]  channel;
    logic [7:0]  group;
    logic [15:0] value;
  } arg_word_s;
  typedef enum logic [1:0] {
    MODE_AUTO = 2'h1,
    MODE_ON   = 2'h2,
    MODE_OFF  = 2'h3
  } gate_mode_e;
  typedef struct packed {
    logic        text_form;
    logic        absolute;
    logic        no_value;
    logic [7:0]  id;
  } cmd_word_s;
endpackage

// ---- rtl/mic_gate_channel.sv ----
// One mic channel's gating settings: hold time, ratio, mode, group, override.
// Assumes the decoder has already checked group and channel; the command code is decoded here.
`include "mixer_gate_defines.svh"
module mic_gate_channel
  import mixer_gate_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sel_i,
  input  wire logic        exec_i,
  input  wire logic [7:0]  id_i,
  input  wire logic        no_value_i,
  input  wire logic [15:0] value_i,
  output logic      [15:0] hold_o,
  output logic      [15:0] ratio_o,
  output gate_mode_e       mode_o,
  output logic      [3:0]  group_o,
  output logic             override_o
);
  logic [15:0] hold_next;
  logic [15:0] ratio_next;
  gate_mode_e  mode_next;
  logic [3:0]  group_next;
  logic        override_next;
  logic        wr;

  always_comb begin
    wr            = sel_i && exec_i && !no_value_i;
    hold_next     = hold_o;
    ratio_next    = ratio_o;
    mode_next     = mode_o;
    group_next    = group_o;
    override_next = override_o;
    if (wr) begin
      case (id_i)
        `ID_HOLD: begin
          if (value_i >= `HOLD_MIN && value_i <= `HOLD_MAX) begin
            hold_next = value_i;
          end
        end
        `ID_RATIO: begin
          if (value_i <= `RATIO_MAX) begin
            ratio_next = value_i;
          end
        end
        `ID_MODE: begin
          if (value_i >= 16'h0001 && value_i <= 16'h0003) begin
            mode_next = gate_mode_e'(value_i[1:0]);
          end
        end
        `ID_ASSIGN: begin
          if (value_i >= 16'h0001 && value_i <= 16'h0008) begin
            group_next = value_i[3:0];
          end
        end
        `ID_OVERRIDE: begin
          if (value_i == 16'h0000 || value_i == 16'h0001) begin
            override_next = value_i[0];
          end else if (value_i == 16'h0002) begin
            override_next = !override_o;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_o     <= `HOLD_RESET;
      ratio_o    <= 16'h0000;
      mode_o     <= MODE_AUTO;
      group_o    <= 4'h1;
      override_o <= 1'b0;
    end else begin
      hold_o     <= hold_next;
      ratio_o    <= ratio_next;
      mode_o     <= mode_next;
      group_o    <= group_next;
      override_o <= override_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hold_write;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr && id_i == `ID_HOLD && value_i >= `HOLD_MIN && value_i <= `HOLD_MAX
      |=> hold_o == $past(value_i);
  endproperty
  a_hold_write: assert property (p_hold_write)
    else $error("hold time not taken");
  property p_ratio_keep;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr && id_i == `ID_RATIO && value_i > `RATIO_MAX |=> $stable(ratio_o);
  endproperty
  a_ratio_keep: assert property (p_ratio_keep)
    else $error("ratio changed by a bad value");
endmodule

// ---- testbench/axi_host_model.sv ----
// Host-side AXI4-Lite master that issues one register access at a time.
// Assumes a slave that answers every channel within the bench timeout.
module axi_host_model (
  input  wire logic        clk_i,
  output logic      [7:0]  awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic      [7:0]  araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  // --------------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------------
  // A random idle gap makes the host prompt at times and slow at others.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    @(posedge clk_i);
    awaddr_o  <= a;
    awvalid_o <= 1'b1;
    wdata_o   <= d;
    wstrb_o   <= 4'hf;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) begin
        r = bresp_i;
        bready_o <= 1'b0;
        done = 1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        done = 1;
      end
    end
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the gain and gating command decoder.
// Assumes the host model drives the register port and the decoder's defines.
`include "mixer_gate_defines.svh"
module testbench
  import mixer_gate_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, report_en;
  logic [7:0]  awaddr, araddr, gate_on, mute;
  logic [31:0] wdata, rdata, reply, rv;
  logic [3:0]  wstrb, line_present;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] gain [8];
  int          n_mismatch = 0, compares = 0, cycles = 0;

  mixer_gain_gating_command_decoder #(.CHANNELS(8))
    mixer_gain_gating_command_decoder_inst (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gate_on_i(gate_on),
    .line_present_i(line_present), .report_en_o(report_en),
    .gain_o(gain), .mute_o(mute));

  axi_host_model host_inst (
    .clk_i(ref_clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
    .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Polls the busy flag so that no fixed execution latency is assumed.
  task automatic cmd(input logic [7:0] id, ch, grp, input logic [15:0] v,
                     input logic nv, ab, tx);
    cmd_word_s c;
    logic [31:0] st;
    c = '{text_form: tx, absolute: ab, no_value: nv, id: id};
    host_inst.wr(`ARG_ADDR, {ch, grp, v}, resp);
    host_inst.wr(`CMD_ADDR, {21'h0, c}, resp);
    st = 32'h1;
    while (st[`STAT_BUSY] !== 1'b0) host_inst.rd(`STAT_ADDR, st, resp);
    host_inst.rd(`REPLY_ADDR, reply, resp);
    chk("reply form", {15'h0, tx}, {15'h0, st[`STAT_TEXT]});
  endtask

  task automatic gcmd(input logic [7:0] id, ch, input int v, input bit nv,
                      input int e);
    cmd(id, ch, `GRP_MIC, v[15:0], nv, 1'b0, 1'($urandom));
    chk("setting", e[15:0], reply[15:0]);
  endtask

  function automatic int gain_exp(int cur, int v, bit ab);
    int e;
    e = ab ? v : cur + v;
    if (e < -65) e = -65;
    if (e > 20) e = 20;
    return e;
  endfunction

  function automatic int hi_of(logic [7:0] id);
    case (id)
      `ID_HOLD:   return 800;
      `ID_RATIO:  return 50;
      `ID_MODE:   return 3;
      `ID_ASSIGN: return 8;
      default:    return 1;
    endcase
  endfunction

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  int         i, r, k, ch, v, lo, hi, g [8];
  bit         ab, mu [8];
  int         corner [6] = '{20, 21, -65, -66, 99, -99};
  logic [7:0] grp_tab [5] = '{`GRP_IN, `GRP_OUT, `GRP_MIC, `GRP_PROC,
                              `GRP_LINE};
  logic [7:0] ids [5] = '{`ID_HOLD, `ID_RATIO, `ID_MODE, `ID_ASSIGN,
                          `ID_OVERRIDE};
  int         md [5] = '{0, 1, 2, 2, 3};
  int         mx [5] = '{0, 1, 0, 1, 1};

  initial begin
    void'($urandom(32'h3038));
    rst_n = 0;
    gate_on = 8'h00;
    line_present = 4'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("mute rst", 16'h0, {8'h0, mute});
    host_inst.rd(`PASS_ADDR, rv, resp);
    chk("passcode", 16'(`PASS_RESET), rv[15:0]);
    host_inst.wr(`PASS_ADDR, 32'h00011442, resp);
    chk("pass wr", 16'h0, {14'h0, resp});
    host_inst.rd(`PASS_ADDR, rv, resp);
    chk("pass lo", 16'h1442, rv[15:0]);
    chk("pass hi", 16'h0001, rv[31:16]);
    cmd(`ID_PASSCODE, 8'h0, 8'h0, 16'h0, 1'b0, 1'b0, 1'b0);
    chk("pass reply", 16'h1442, reply[23:8]);
    host_inst.rd(8'h40, rv, resp);
    chk("bad rd", 16'h2, {14'h0, resp});
    chk("bad data", 16'h0, rv[15:0]);
    host_inst.wr(8'h40, 32'h1, resp);
    chk("bad wr", 16'h2, {14'h0, resp});
    $display("test reset done");
    cmd(`ID_GAIN, 8'h01, `GRP_IN, 16'h000f, 1'b1, 1'b0, 1'b0);
    chk("gain noval", 16'h0, gain[0]);
    for (i = 0; i < 30; i++) begin
      ch = $urandom_range(1, 8);
      ab = $urandom_range(0, 1) || mu[ch-1];
      v = ab ? $urandom_range(0, 198) - 99 : $urandom_range(0, 20) - 10;
      if (i < 6) begin
        v = corner[i];
        ab = 1;
      end
      if (!ab && g[ch-1] + v < -65) v = -v;
      cmd(`ID_GAIN, ch[7:0], grp_tab[$urandom_range(0, 4)], v[15:0], 1'b0,
          ab, 1'($urandom));
      mu[ch-1] = ab && v < -65;
      chk("mute", {15'h0, mu[ch-1]}, {15'h0, mute[ch-1]});
      if (!mu[ch-1]) begin
        g[ch-1] = gain_exp(g[ch-1], v, ab);
        chk("gain", g[ch-1][15:0], gain[ch-1]);
        chk("gain reply", g[ch-1][15:0], reply[15:0]);
      end
    end
    $display("test gain done");
    gcmd(`ID_HOLD, 8'h01, 0, 1, `HOLD_RESET);
    for (r = 0; r < 3; r++) begin
      foreach (ids[k]) begin
        ch = $urandom_range(1, 8);
        hi = hi_of(ids[k]);
        lo = (ids[k] == `ID_HOLD) ? 10 : (hi == 3 || hi == 8) ? 1 : 0;
        v = (ids[k] == `ID_MODE) ? r + 1 : $urandom_range(lo, hi);
        gcmd(ids[k], ch[7:0], v, 0, v);
        gcmd(ids[k], ch[7:0], 0, 1, v);
        gcmd(ids[k], ch[7:0], hi + 1 + (hi == 1), 0, v);
        if (lo > 0) gcmd(ids[k], ch[7:0], lo - 1, 0, v);
        if (hi == 1) begin
          gcmd(ids[k], ch[7:0], 2, 0, 1 - v);
          gcmd(ids[k], ch[7:0], 2, 0, v);
        end
      end
    end
    $display("test gating done");
    foreach (md[k]) begin
      cmd(`ID_REPORT, 8'h0, 8'h0, md[k][15:0], 1'b0, 1'b0, 1'b0);
      chk("report", mx[k][15:0], {15'h0, report_en});
    end
    $display("test report done");
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      gate_on <= (i == 0) ? 8'h49 : 8'($urandom);
      line_present <= 4'($urandom);
      @(posedge ref_clk);
      cmd(`ID_GATE_STAT, 8'h0, 8'h0, 16'h0, 1'b0, 1'b0, i[0]);
      lo = i[0] ? int'(line_present) : 0;
      chk("gate", {8'h0, gate_on}, {8'h0, reply[7:0]});
      chk("line", lo[15:0], {12'h0, reply[11:8]});
      host_inst.rd(`GATE_ADDR, rv, resp);
      chk("gate reg", {8'h0, gate_on}, {8'h0, rv[7:0]});
    end
    $display("test gate status done");
    final_report();
  end
endmodule
